//--- hw/opu_uart.v
// Single-wire half-duplex programming UART with fuse working copy.
// Assumes an external pull-up on the line and fuse cells outside this block.
`include "opu_defines.vh"

module opu_uart #(
  parameter [23:0] TIMEOUT_CYC = `OPU_TIMEOUT_CYC,
  parameter [15:0] KEY         = `OPU_KEY_DEFAULT,
  parameter        FIFO_DEPTH  = `OPU_FIFO_DEPTH
) (
  // Clock and reset
  input  wire         sys_clk_i,
  input  wire         reset_i,
  // Shared programming line
  input  wire         line_i,
  output wire         line_o,
  output wire         line_oe_o,
  // Fuse cells
  input  wire [127:0] fuse_i,
  output wire [127:0] fuse_set_o,
  output wire         fuse_burn_o,
  // Sensor side
  input  wire [13:0]  angle_i,
  output wire [127:0] work_o,
  output wire         comm_mode_o
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_MEAS = 3'h1;
  localparam [2:0] S_SKIP = 3'h2;
  localparam [2:0] S_RXCH = 3'h3;
  localparam [2:0] S_GAP  = 3'h4;
  localparam [2:0] S_TX   = 3'h5;

  localparam [1:0] PH_SYNC = 2'h0;
  localparam [1:0] PH_CMD  = 2'h1;
  localparam [1:0] PH_LO   = 2'h2;
  localparam [1:0] PH_HI   = 2'h3;

  // ========================================================================
  // Line input synchroniser and edges
  // ========================================================================
  reg  s1_r;
  reg  s2_r;
  reg  s3_r;
  reg  rx_r;
  reg  rx_d_r;
  wire fall;
  wire rise;

  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s1_r   <= 1'b1;
      s2_r   <= 1'b1;
      s3_r   <= 1'b1;
      rx_r   <= 1'b1;
      rx_d_r <= 1'b1;
    end
    else
    begin
      s1_r   <= line_i;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      if (s2_r == s3_r)
        rx_r <= s3_r;
      rx_d_r <= rx_r;
    end
  end

  assign fall = rx_d_r & ~rx_r;
  assign rise = ~rx_d_r & rx_r;

  // ========================================================================
  // State
  // ========================================================================
  reg  [2:0]   state_r;
  reg  [1:0]   phase_r;
  reg  [15:0]  cnt_r;
  reg  [3:0]   idx_r;
  reg  [8:0]   sh_r;
  reg  [6:0]   addr_r;
  reg  [7:0]   lo_r;
  reg  [15:0]  baud_r;
  reg          manual_r;
  reg  [18:0]  meas_r;
  reg  [23:0]  to_cnt_r;
  reg          wr_en_r;
  reg  [15:0]  wr_data_r;
  reg          burn_r;
  reg  [127:0] set_r;
  reg          comm_r;
  reg          init_r;
  reg  [1:0]   push_cnt_r;

  wire [127:0] work_w;
  wire [127:0] burn_mask;
  wire [18:0]  meas_inc;
  wire [15:0]  rx_data;
  wire [1:0]   start_phase;
  wire         rx_watch;
  wire         user_lock;
  wire         fact_lock;
  wire         par_bad;
  wire [15:0]  half_bit;
  wire [15:0]  bit_last;

  assign user_lock   = fuse_i[`OPU_USER_LOCK_BIT];
  assign fact_lock   = fuse_i[`OPU_FACT_LOCK_BIT];
  assign meas_inc    = meas_r + 19'h00001;
  assign rx_data     = {sh_r[7:0], lo_r};
  assign start_phase = manual_r ? PH_CMD : PH_SYNC;
  assign half_bit    = {1'b0, baud_r[15:1]};
  assign bit_last    = baud_r - 16'h0001;
  assign par_bad     = ^sh_r;
  assign rx_watch    = ((state_r == S_IDLE) && (phase_r != start_phase))
                       || (state_r == S_MEAS) || (state_r == S_SKIP)
                       || (state_r == S_RXCH);

  // ========================================================================
  // Read data selection
  // ========================================================================
  reg  [15:0] rd_word;
  reg         rd_known;

  always @*
  begin
    rd_word  = 16'h0000;
    rd_known = 1'b0;
    if (addr_r <= `OPU_ADDR_WORK_LAST)
    begin
      rd_word  = work_w[{addr_r[2:0], 4'h0} +: 16];
      rd_known = 1'b1;
    end
    else if (addr_r == `OPU_ADDR_ANGLE)
    begin
      rd_word  = {2'b00, angle_i};
      rd_known = 1'b1;
    end
    else if (addr_r == `OPU_ADDR_BIT_RATE)
    begin
      rd_word  = baud_r;
      rd_known = 1'b1;
    end
  end

  function rd_ok;
    input [6:0] a;
    begin
      rd_ok = (a <= `OPU_ADDR_WORK_LAST) || (a == `OPU_ADDR_ANGLE)
              || (a == `OPU_ADDR_BIT_RATE);
    end
  endfunction

  // ========================================================================
  // Answer FIFO and transmitter wiring
  // ========================================================================
  wire       fifo_in_valid;
  wire       fifo_in_ready;
  wire [7:0] fifo_in_data;
  wire       fifo_out_valid;
  wire       fifo_out_ready;
  wire [7:0] fifo_out_data;
  reg        tx_busy_r;

  assign fifo_in_valid  = (state_r == S_GAP) && (push_cnt_r != 2'h2) && rd_known;
  assign fifo_in_data   = push_cnt_r[0] ? rd_word[15:8] : rd_word[7:0];
  assign fifo_out_ready = (state_r == S_TX) && !tx_busy_r;

  opu_fifo #(
    .W  (8),
    .D  (FIFO_DEPTH),
    .AW (2)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // ========================================================================
  // Protocol state machine
  // ========================================================================
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r    <= S_IDLE;
      phase_r    <= PH_SYNC;
      cnt_r      <= 16'h0000;
      idx_r      <= 4'h0;
      sh_r       <= 9'h000;
      addr_r     <= 7'h00;
      lo_r       <= 8'h00;
      baud_r     <= `OPU_BIT_RATE_RESET;
      manual_r   <= 1'b0;
      meas_r     <= 19'h00000;
      to_cnt_r   <= 24'h000000;
      wr_en_r    <= 1'b0;
      wr_data_r  <= 16'h0000;
      burn_r     <= 1'b0;
      set_r      <= 128'h0;
      comm_r     <= 1'b0;
      init_r     <= 1'b0;
      push_cnt_r <= 2'h0;
    end
    else
    begin
      wr_en_r <= 1'b0;
      burn_r  <= 1'b0;
      init_r  <= 1'b1;
      if (!init_r)
        comm_r <= ~user_lock;
      if (fall || !rx_watch)
        to_cnt_r <= 24'h000000;
      else
        to_cnt_r <= to_cnt_r + 24'h000001;
      if (fifo_in_valid && fifo_in_ready)
        push_cnt_r <= push_cnt_r + 2'h1;

      if (rx_watch && (to_cnt_r == TIMEOUT_CYC))
      begin
        state_r <= S_IDLE;
        phase_r <= start_phase;
      end
      else
      begin
        case (state_r)
          S_IDLE:
          begin
            if (phase_r == PH_SYNC && manual_r)
              phase_r <= PH_CMD;
            if (fall && comm_r && init_r)
            begin
              idx_r <= 4'h0;
              if (phase_r == PH_SYNC && !manual_r)
              begin
                state_r <= S_MEAS;
                meas_r  <= 19'h00000;
              end
              else
              begin
                state_r <= S_RXCH;
                cnt_r   <= half_bit;
              end
            end
          end
          S_MEAS:
          begin
            meas_r <= meas_inc;
            if (fall)
            begin
              idx_r <= idx_r + 4'h1;
              if (idx_r == `OPU_SYNC_FALLS)
              begin
                baud_r  <= meas_inc[18:3];
                state_r <= S_SKIP;
              end
            end
          end
          S_SKIP:
          begin
            if (rise)
            begin
              state_r <= S_IDLE;
              phase_r <= PH_CMD;
            end
          end
          S_RXCH:
          begin
            if (cnt_r != 16'h0000)
              cnt_r <= cnt_r - 16'h0001;
            else
            begin
              cnt_r <= bit_last;
              idx_r <= idx_r + 4'h1;
              if (idx_r == 4'h0)
              begin
                if (rx_r)
                  state_r <= S_IDLE;
              end
              else if (idx_r <= `OPU_PAR_IDX)
                sh_r <= {rx_r, sh_r[8:1]};
              else if (!rx_r || par_bad)
              begin
                state_r <= S_IDLE;
                phase_r <= start_phase;
              end
              else
              begin
                state_r <= S_IDLE;
                case (phase_r)
                  PH_CMD:
                  begin
                    addr_r <= sh_r[6:0];
                    if (sh_r[`OPU_RNW_BIT])
                    begin
                      phase_r <= start_phase;
                      if (rd_ok(sh_r[6:0]))
                      begin
                        state_r    <= S_GAP;
                        cnt_r      <= half_bit;
                        idx_r      <= 4'h0;
                        push_cnt_r <= 2'h0;
                      end
                    end
                    else
                      phase_r <= PH_LO;
                  end
                  PH_LO:
                  begin
                    lo_r    <= sh_r[7:0];
                    phase_r <= PH_HI;
                  end
                  default:
                  begin
                    phase_r <= start_phase;
                    if (addr_r <= `OPU_ADDR_WORK_LAST)
                    begin
                      wr_en_r   <= 1'b1;
                      wr_data_r <= rx_data;
                    end
                    else if (addr_r == `OPU_ADDR_BURN && rx_data == KEY)
                    begin
                      burn_r <= 1'b1;
                      set_r  <= burn_mask;
                    end
                    else if (addr_r == `OPU_ADDR_GO_FUNC && rx_data == KEY)
                      comm_r <= 1'b0;
                    else if (addr_r == `OPU_ADDR_BIT_RATE)
                    begin
                      baud_r   <= rx_data;
                      manual_r <= (rx_data != 16'h0000);
                      phase_r  <= (rx_data != 16'h0000) ? PH_CMD : PH_SYNC;
                    end
                  end
                endcase
              end
            end
          end
          S_GAP:
          begin
            if (cnt_r != 16'h0000)
              cnt_r <= cnt_r - 16'h0001;
            else if (idx_r == `OPU_GAP_BITS)
            begin
              if (push_cnt_r == 2'h2)
                state_r <= S_TX;
            end
            else
            begin
              cnt_r <= bit_last;
              idx_r <= idx_r + 4'h1;
            end
          end
          S_TX:
          begin
            if (!tx_busy_r && !fifo_out_valid)
              state_r <= S_IDLE;
          end
          default:
            state_r <= S_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // Transmitter
  // ========================================================================
  reg  [10:0] tx_sh_r;
  reg  [15:0] tx_cnt_r;
  reg  [3:0]  tx_idx_r;
  reg         oe_r;

  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 11'h7FF;
      tx_cnt_r  <= 16'h0000;
      tx_idx_r  <= 4'h0;
      oe_r      <= 1'b0;
    end
    else if (!tx_busy_r)
    begin
      if (fifo_out_valid && fifo_out_ready)
      begin
        tx_sh_r   <= {1'b1, ^fifo_out_data, fifo_out_data, 1'b0};
        tx_busy_r <= 1'b1;
        tx_cnt_r  <= bit_last;
        tx_idx_r  <= 4'h0;
        oe_r      <= 1'b1;
      end
    end
    else if (tx_cnt_r != 16'h0000)
      tx_cnt_r <= tx_cnt_r - 16'h0001;
    else if (tx_idx_r == `OPU_STOP_IDX)
    begin
      tx_busy_r <= 1'b0;
      oe_r      <= 1'b0;
    end
    else
    begin
      tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
      oe_r     <= ~tx_sh_r[1];
      tx_idx_r <= tx_idx_r + 4'h1;
      tx_cnt_r <= bit_last;
    end
  end

  // ========================================================================
  // Working copy words and burn mask
  // ========================================================================
  genvar w;
  generate
    for (w = 0; w < `OPU_WORDS; w = w + 1)
    begin : g_word
      reg  [15:0] word_r;
      wire        wr_open;
      wire        burn_open;

      assign wr_open   = ~user_lock & ((w < `OPU_FACT_FIRST_WORD) | ~fact_lock);
      assign burn_open = (w < `OPU_FACT_FIRST_WORD) ? ~user_lock : ~fact_lock;
      assign work_w[w*16 +: 16]    = word_r;
      assign burn_mask[w*16 +: 16] = word_r & ~fuse_i[w*16 +: 16]
                                     & {16{burn_open}};

      always @(posedge sys_clk_i or posedge reset_i)
      begin
        if (reset_i)
          word_r <= 16'h0000;
        else if (!init_r)
          word_r <= fuse_i[w*16 +: 16];
        else if (burn_r)
          word_r <= word_r | fuse_i[w*16 +: 16];
        else if (wr_en_r && addr_r[2:0] == w && wr_open)
          word_r <= wr_data_r;
      end
    end
  endgenerate

  // ========================================================================
  // Outputs
  // ========================================================================
  assign line_o      = 1'b0;
  assign line_oe_o   = oe_r;
  assign fuse_set_o  = set_r;
  assign fuse_burn_o = burn_r;
  assign work_o      = work_w;
  assign comm_mode_o = comm_r;

endmodule // opu_uart

//--- hw/opu_defines.vh
// Constants of the one-time-programmable store programming UART.
// Included by the design files of this block only; holds definitions only.
`ifndef OPU_DEFINES_VH
`define OPU_DEFINES_VH

// ==========================================================================
// Register addresses
// ==========================================================================
`define OPU_ADDR_WORK_LAST   7'h07
`define OPU_ADDR_ANGLE       7'h10
`define OPU_ADDR_BURN        7'h41
`define OPU_ADDR_BIT_RATE    7'h42
`define OPU_ADDR_GO_FUNC     7'h60

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define OPU_RNW_BIT          7
`define OPU_FUSE_BITS        128
`define OPU_WORDS            8
`define OPU_FACT_FIRST_WORD  7
`define OPU_USER_LOCK_BIT    0
`define OPU_FACT_LOCK_BIT    112
`define OPU_KEY_DEFAULT      16'h5A3C
`define OPU_BIT_RATE_RESET   16'h0000

// ==========================================================================
// Character layout and timing
// ==========================================================================
`define OPU_STOP_IDX         4'hA
`define OPU_PAR_IDX          4'h9
`define OPU_SYNC_FALLS       4'h3
`define OPU_GAP_BITS         4'h7
`define OPU_TIMEOUT_CYC      24'h013880
`define OPU_FIFO_DEPTH       4

`endif

//--- hw/opu_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; depth is a power of two matching the pointer width.
module opu_fifo #(
  parameter W  = 8,
  parameter D  = 4,
  parameter AW = 2
) (
  // Clock and reset
  input  wire          sys_clk_i,
  input  wire          reset_i,
  // Fill side
  input  wire          in_valid_i,
  output wire          in_ready_o,
  input  wire [W-1:0]  in_data_i,
  // Drain side
  output wire          out_valid_o,
  input  wire          out_ready_i,
  output wire [W-1:0]  out_data_o
);

  reg  [W-1:0]  mem_r [0:D-1];
  reg  [AW-1:0] wr_ptr_r;
  reg  [AW-1:0] rd_ptr_r;
  reg  [AW:0]   level_r;
  wire          push;
  wire          pop;

  localparam [AW:0] FULL_LEVEL = D[AW:0];

  assign in_ready_o  = (level_r != FULL_LEVEL);
  assign out_valid_o = (level_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // ========================================================================
  // Storage
  // ========================================================================
  always @(posedge sys_clk_i)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_i;
  end

  // ========================================================================
  // Pointers and level
  // ========================================================================
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      level_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        level_r <= level_r + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        level_r <= level_r - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // opu_fifo

//--- tb/opu_uart_props.sv
// Assertions on the ports of the programming UART top module.
// Assumes one clock domain; the bind statement stands at the foot.
module opu_uart_props (
  // Clock and reset
  input logic         sys_clk_i,
  input logic         reset_i,
  // Shared line
  input logic         line_i,
  input logic         line_o,
  input logic         line_oe_o,
  // Fuses and sensor side
  input logic [127:0] fuse_i,
  input logic [127:0] fuse_set_o,
  input logic         fuse_burn_o,
  input logic [13:0]  angle_i,
  input logic [127:0] work_o,
  input logic         comm_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  a_line_pull_only: assert property (line_o == 1'b0)
    else $error("line data not low");
  a_start_mode: assert property ($fell(reset_i) |=> comm_mode_o == !fuse_i[0])
    else $error("start mode wrong");
  a_work_load: assert property ($fell(reset_i) |=> work_o == fuse_i)
    else $error("working copy not loaded");
  a_func_stays: assert property (!comm_mode_o && !$fell(reset_i) |=> !comm_mode_o)
    else $error("left functional mode");
  a_burn_new_only: assert property (fuse_burn_o |-> (fuse_set_o & fuse_i) == '0)
    else $error("burn of programmed cell");
  a_user_lock: assert property (fuse_burn_o && fuse_i[0] |-> fuse_set_o[111:0] == '0)
    else $error("burn in locked user region");
  a_fact_lock: assert property (fuse_burn_o && fuse_i[112] |-> fuse_set_o[127:112] == '0)
    else $error("burn in locked factory region");
  a_burn_pulse: assert property (fuse_burn_o |=> !fuse_burn_o)
    else $error("burn pulse too long");
  a_drive_in_comm: assert property (line_oe_o |-> comm_mode_o)
    else $error("line driven outside communication");

  c_burn: cover property (fuse_burn_o);
  c_answer: cover property ($rose(line_oe_o));
  c_func: cover property ($fell(comm_mode_o));
endmodule // opu_uart_props

bind opu_uart opu_uart_props u_props (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .line_i(line_i), .line_o(line_o),
  .line_oe_o(line_oe_o), .fuse_i(fuse_i), .fuse_set_o(fuse_set_o),
  .fuse_burn_o(fuse_burn_o), .angle_i(angle_i), .work_o(work_o),
  .comm_mode_o(comm_mode_o)
);

//--- tb/opu_tool.sv
// Programming tool model on the shared line, open drain with pull-up.
// Assumes the bench calls its tasks just after a falling clock edge.
module opu_tool (
  // Clock
  input  wire logic sys_clk_i,
  // Shared line
  input  wire logic line_i,
  output logic      pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Character transfer
  int t_bit = 16;
  initial pull_o = 1'b0;

  task automatic tx(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      pull_o = ~f[i];
      repeat (t_bit) @(negedge sys_clk_i);
    end
  endtask

  task automatic rx(output logic [7:0] d, output int w, output logic ok);
    logic [10:0] f;
    w = 0;
    while (line_i === 1'b1 && w < 40 * t_bit)
    begin
      @(negedge sys_clk_i);
      w++;
    end
    ok = (line_i === 1'b0);
    repeat (t_bit / 2) @(negedge sys_clk_i);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = line_i;
      if (i < 10) repeat (t_bit) @(negedge sys_clk_i);
    end
    d = f[8:1];
    ok = ok && !f[0] && f[10] && (f[9] == ^d);
  endtask
endmodule // opu_tool

//--- tb/opu_uart_tb.sv
// Self-checking bench for the programming UART.
// Assumes the tool model on the line; fuse cells are modelled here.
module opu_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals and models
  localparam logic [15:0] TEST_KEY = 16'h5A3C; // Arbitrary key value
  logic         sys_clk, reset, tool_pull, line, line_oe, line_o_w, burn, comm, sy;
  logic [127:0] fuse, fuse_set, work;
  logic [13:0]  angle;
  int           mismatches, n_tests, n_burn;

  assign line = ~(tool_pull | (line_oe & ~line_o_w));
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (burn)
    begin
      fuse <= fuse | fuse_set;
      n_burn <= n_burn + 1;
    end

  opu_uart #(.TIMEOUT_CYC(24'h0007D0), .KEY(TEST_KEY)) DUT (
    .sys_clk_i(sys_clk), .reset_i(reset), .line_i(line), .line_o(line_o_w),
    .line_oe_o(line_oe), .fuse_i(fuse), .fuse_set_o(fuse_set), .fuse_burn_o(burn),
    .angle_i(angle), .work_o(work), .comm_mode_o(comm));
  opu_tool tool (.sys_clk_i(sys_clk), .line_i(line), .pull_o(tool_pull));

  // ==========================================================================
  // Tasks
  task automatic conclude;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s exp=%h got=%h", nm, exp, got);
    end
  endtask

  task automatic rst;
    reset = 1'b1;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic req(input logic [7:0] cmd);
    if (sy) tool.tx(8'h55, 1'b0);
    tool.tx(cmd, 1'b0);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic bad, input int sp);
    req({1'b0, a});
    tool.tx(d[7:0], 1'b0);
    repeat (sp) @(negedge sys_clk);
    tool.tx(d[15:8], bad);
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [7:0] lo, hi;
    int         w, w2;
    logic       ok, ok2;
    req({1'b1, a});
    tool.rx(lo, w, ok);
    tool.rx(hi, w2, ok2);
    chk("answer", 1'h1, ok && ok2);
    if (!(ok && ok2)) conclude;
    chk("gap", 1'h1, w >= 7 * tool.t_bit && w < 8 * tool.t_bit);
    chk("rdata", exp, {hi, lo});
    repeat (2 * tool.t_bit) @(negedge sys_clk);
  endtask

  // ==========================================================================
  // Sequence
  initial
  begin
    sys_clk = 1'b0;
    fuse = '0;
    angle = 14'h2ABC;
    sy = 1'b1;
    rst();
    chk("comm", 1'h1, comm);
    wr(7'h00, 16'h1234, 1'b0, 0);
    chk("work0", 16'h1234, work[15:0]);
    rd(7'h00, 16'h1234);
    rd(7'h10, 16'h2ABC);
    rd(7'h42, 16'h0010);
    $display("test basic done");
    wr(7'h00, 16'hFFFF, 1'b1, 0);
    wr(7'h30, 16'hFFFF, 1'b0, 0);
    chk("work0", 16'h1234, work[15:0]);
    wr(7'h01, 16'hA5C3, 1'b0, 11);
    chk("work1", 16'hA5C3, work[31:16]);
    $display("test refuse done");
    req(8'h02);
    tool.tx(8'h77, 1'b0);
    repeat (2200) @(negedge sys_clk);
    wr(7'h02, 16'h0F0F, 1'b0, 0);
    chk("work2", 16'h0F0F, work[47:32]);
    $display("test timeout done");
    wr(7'h42, 16'h0014, 1'b0, 0);
    sy = 1'b0;
    tool.t_bit = 20;
    wr(7'h03, 16'h00C3, 1'b0, 0);
    chk("work3", 16'h00C3, work[63:48]);
    rd(7'h42, 16'h0014);
    wr(7'h42, 16'h0000, 1'b0, 0);
    sy = 1'b1;
    tool.t_bit = 16;
    $display("test manual done");
    wr(7'h41, TEST_KEY, 1'b0, 0);
    chk("burns", 1, n_burn);
    chk("set", 128'h00C30F0FA5C31234, fuse_set);
    wr(7'h00, 16'h1238, 1'b0, 0);
    wr(7'h41, TEST_KEY, 1'b0, 0);
    chk("set0", 16'h0008, fuse_set[15:0]);
    chk("work0", 16'h123C, work[15:0]);
    wr(7'h41, ~TEST_KEY, 1'b0, 0);
    chk("burns", 2, n_burn);
    $display("test burn done");
    wr(7'h60, TEST_KEY, 1'b0, 0);
    chk("comm", 1'h0, comm);
    wr(7'h04, 16'h1111, 1'b0, 0);
    chk("work4", 16'h0000, work[79:64]);
    rst();
    chk("comm", 1'h1, comm);
    wr(7'h00, 16'h0001, 1'b0, 0);
    wr(7'h41, TEST_KEY, 1'b0, 0);
    chk("set", 128'h1, fuse_set);
    wr(7'h01, 16'hFFFF, 1'b0, 0);
    chk("work1", 16'hA5C3, work[31:16]);
    rst();
    chk("comm", 1'h0, comm);
    chk("work", fuse, work);
    $display("test lock done");
    conclude();
  end
endmodule // opu_uart_tb
